// *** hw/atsc_pkg.sv ***
package atsc_pkg;

   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned INIT_TIME_NS = 20000;
   localparam int unsigned INIT_CYC = INIT_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned SEC_NS = 1000000000;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned SEC_CYC_DFLT = SEC_NS / CLK_PERIOD_NS;
   localparam int unsigned MS_CYC_DFLT = MS_NS / CLK_PERIOD_NS;
   localparam logic [11:0] INIT_LAST = 12'(INIT_CYC - 1);
   localparam logic [11:0] TBL_ENTRIES = 12'h200;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices and byte addresses
   localparam logic [15:0] IDX_UPPER_RB = 16'h1806;
   localparam logic [15:0] IDX_CMD_STS = 16'h1808;
   localparam logic [15:0] IDX_AGING_CFG = 16'h1809;
   localparam logic [15:0] ADDR_UPPER_RB = 16'(IDX_UPPER_RB * 4);
   localparam logic [15:0] ADDR_CMD_STS = 16'(IDX_CMD_STS * 4);
   localparam logic [15:0] ADDR_AGING_CFG = 16'(IDX_AGING_CFG * 4);
   localparam logic [15:0] ADDR_GLOBAL_CTRL = 16'h6040;
   localparam logic [15:0] ADDR_IRQ_STS = 16'h6044;
   localparam logic [15:0] ADDR_IRQ_MASK = 16'h6048;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int unsigned RB_END = 27;
   localparam int unsigned RB_VALID = 26;
   localparam int unsigned RB_AGE1 = 25;
   localparam int unsigned RB_STATIC = 24;
   localparam int unsigned RB_AGE0 = 23;
   localparam int unsigned RB_PRIO_EN = 22;
   localparam int unsigned RB_PRIO_LSB = 19;
   localparam int unsigned RB_PORT_LSB = 16;
   localparam int unsigned STS_INIT_DONE = 1;
   localparam int unsigned STS_PENDING = 0;
   localparam int unsigned CFG_AGE_LSB = 16;
   localparam int unsigned CFG_BCAST = 2;
   localparam int unsigned CFG_AGE_EN = 1;
   localparam int unsigned CFG_AGE_TEST = 0;
   localparam int unsigned IRQ_INIT = 0;
   localparam int unsigned IRQ_CMD = 1;
   localparam int unsigned IRQ_FOUND = 2;

   // Reset values
   localparam logic [11:0] AGE_TIME_RST = 12'h129;
   localparam logic AGE_EN_RST = 1'b1;
   localparam logic AGE_TEST_RST = 1'b0;
   localparam logic BCAST_RST = 1'b0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0]
   {
      ST_INIT = 2'h1,
      ST_RUN = 2'h2
   } atsc_state_e;

endpackage : atsc_pkg

// *** hw/atsc_top.sv ***
//Behaviour
//- Entry priority used only with both enables
//- Port field top bit: single versus multiple
//- Port codes decode; 011 reserved, no ports
//- Low half-word returns last sixteen MAC bits
//- Reset clears init flag, init, then sets
//- Init about 20 us, drop packets meanwhile
//- Pending flag high during command, self-clears
//- Aging period is field plus one units
//- Aging field resets to 298 second period
//- Broadcast entries allowed only when bit set
//- Aging runs only while enable bit set
//- Test bit switches aging unit to milliseconds
//- Valid clears on get command, sets on find
//- Aging never evicts static, evicts idle dynamic
module atsc_top
   import atsc_pkg::*;
#(
   parameter int unsigned SEC_CYC = SEC_CYC_DFLT,
   parameter int unsigned MS_CYC = MS_CYC_DFLT
)
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic [15:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [15:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_i_unused_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic cmd_start_i,
   input wire logic cmd_done_i,
   input wire logic cmd_get_i,
   input wire logic entry_load_i,
   input wire logic entry_found_i,
   input wire logic entry_end_i,
   input wire logic [31:0] entry_upper_i,
   input wire logic match_valid_i,
   input wire logic match_prio_en_i,
   input wire logic [2:0] match_prio_i,
   input wire logic [2:0] match_ports_i,
   input wire logic age_cand_valid_i,
   input wire logic age_cand_static_i,
   input wire logic age_cand_idle_i,
   output logic init_done_o,
   output logic drop_rx_o,
   output logic tbl_clr_we_o,
   output logic [8:0] tbl_clr_addr_o,
   output logic fwd_prio_valid_o,
   output logic [2:0] fwd_prio_o,
   output logic [2:0] fwd_port_mask_o,
   output logic allow_bcast_o,
   output logic age_sweep_o,
   output logic age_evict_o,
   output logic irq_o
);

   typedef struct packed {
      atsc_state_e st;
      logic [11:0] init_cnt;
      logic init_done;
      logic drop;
      logic pending;
      logic [31:0] rb;
      logic [11:0] age_time;
      logic age_en;
      logic age_test;
      logic bcast;
      logic glob_prio;
      logic [27:0] tick_cnt;
      logic [12:0] unit_cnt;
      logic sweep;
      logic evict;
      logic [2:0] irq_sts;
      logic [2:0] irq_mask;
      logic irq;
      logic prio_valid;
      logic [2:0] prio;
      logic [2:0] pmask;
      logic tbl_we;
      logic [8:0] tbl_addr;
      logic aw_got;
      logic [15:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } atsc_regs_s;

   localparam logic [27:0] SEC_LAST = 28'(SEC_CYC - 1);
   localparam logic [27:0] MS_LAST = 28'(MS_CYC - 1);

   atsc_regs_s q;
   atsc_regs_s d;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [2:0] port_decode(input logic [2:0] code);
      logic [2:0] m;
      m = 3'h0;
      case (code)
         3'h0: m = 3'h1;
         3'h1: m = 3'h2;
         3'h2: m = 3'h4;
         3'h4: m = 3'h3;
         3'h5: m = 3'h5;
         3'h6: m = 3'h6;
         3'h7: m = 3'h7;
         default: m = 3'h0;
      endcase
      return m;
   endfunction : port_decode

   function automatic logic [31:0] cfg_word(input atsc_regs_s r);
      logic [31:0] w;
      w = 32'h0;
      w[CFG_AGE_LSB +: 12] = r.age_time;
      w[CFG_BCAST] = r.bcast;
      w[CFG_AGE_EN] = r.age_en;
      w[CFG_AGE_TEST] = r.age_test;
      return w;
   endfunction : cfg_word

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic [31:0] rd;
      logic [31:0] wr;
      logic [2:0] ev;
      logic [2:0] clr;
      logic hit;
      logic [27:0] last;
      rd = 32'h0;
      wr = 32'h0;
      ev = 3'h0;
      clr = 3'h0;
      hit = 1'b1;
      last = q.age_test ? MS_LAST : SEC_LAST;
      d = q;

      // Table initialisation after reset
      d.tbl_we = 1'b0;
      case (q.st)
         ST_INIT:
         begin
            d.tbl_we = q.init_cnt < TBL_ENTRIES;
            d.tbl_addr = q.init_cnt[8:0];
            d.init_cnt = q.init_cnt + 12'h1;
            if (q.init_cnt == INIT_LAST)
            begin
               d.st = ST_RUN;
               d.init_done = 1'b1;
            end
         end
         ST_RUN: d.init_cnt = q.init_cnt;
         default: d.st = ST_INIT;
      endcase
      d.drop = !d.init_done;

      // Set wins over clear: a command starting as the last ends stays pending
      if (cmd_start_i)
         d.pending = 1'b1;
      else if (cmd_done_i)
         d.pending = 1'b0;
      if (entry_load_i)
      begin
         d.rb = entry_upper_i & 32'h0fff_ffff;
         d.rb[RB_VALID] = entry_found_i;
         d.rb[RB_END] = entry_end_i;
      end
      else if (cmd_get_i)
         d.rb[RB_VALID] = 1'b0;

      // Forwarding priority and port mask for a matched destination
      d.prio_valid = match_valid_i && match_prio_en_i && q.glob_prio;
      d.prio = match_prio_i;
      d.pmask = match_valid_i ? port_decode(match_ports_i) : 3'h0;
      // Aging time base; counters park while aging is off
      d.sweep = 1'b0;
      if (!q.age_en)
      begin
         d.tick_cnt = 28'h0;
         d.unit_cnt = 13'h0;
      end
      else if (q.tick_cnt >= last)
      begin
         d.tick_cnt = 28'h0;
         if (q.unit_cnt >= {1'b0, q.age_time})
         begin
            d.unit_cnt = 13'h0;
            d.sweep = 1'b1;
         end
         else
            d.unit_cnt = q.unit_cnt + 13'h1;
      end
      else
         d.tick_cnt = q.tick_cnt + 28'h1;
      d.evict = q.age_en && age_cand_valid_i && age_cand_idle_i
                && !age_cand_static_i;
      ev[IRQ_INIT] = d.init_done && !q.init_done;
      ev[IRQ_CMD] = q.pending && cmd_done_i;
      ev[IRQ_FOUND] = entry_load_i && entry_found_i;

      // AXI4-Lite write: address and data in either order
      if (s_axi_awvalid_i && q.awready)
      begin
         d.aw_got = 1'b1;
         d.awaddr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && q.wready)
      begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata_i;
         d.wstrb = s_axi_wstrb_i;
      end
      if (q.bvalid && s_axi_bready_i)
         d.bvalid = 1'b0;
      if (q.aw_got && q.w_got && !q.bvalid)
      begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         case (q.awaddr)
            ADDR_AGING_CFG: rd = cfg_word(q);
            ADDR_GLOBAL_CTRL: rd = {31'h0, q.glob_prio};
            ADDR_IRQ_MASK: rd = {29'h0, q.irq_mask};
            ADDR_IRQ_STS, ADDR_UPPER_RB, ADDR_CMD_STS: rd = 32'h0;
            default: hit = 1'b0;
         endcase
         wr = rd;
         for (int b = 0; b < 4; b++)
            if (q.wstrb[b])
               wr[8*b +: 8] = q.wdata[8*b +: 8];
         // Read-only registers and reserved bits take no write
         case (q.awaddr)
            ADDR_AGING_CFG:
            begin
               d.age_time = wr[CFG_AGE_LSB +: 12];
               d.bcast = wr[CFG_BCAST];
               d.age_en = wr[CFG_AGE_EN];
               d.age_test = wr[CFG_AGE_TEST];
            end
            ADDR_GLOBAL_CTRL: d.glob_prio = wr[0];
            ADDR_IRQ_STS: clr = wr[2:0];
            ADDR_IRQ_MASK: d.irq_mask = wr[2:0];
            default: d.bresp = hit ? RESP_OKAY : RESP_SLVERR;
         endcase
      end
      d.awready = !d.aw_got && !d.bvalid;
      d.wready = !d.w_got && !d.bvalid;

      // Event wins over write-one-to-clear in the same cycle
      d.irq_sts = (q.irq_sts & ~clr) | ev;
      d.irq = |(d.irq_sts & d.irq_mask);

      // AXI4-Lite read
      if (q.rvalid && s_axi_rready_i)
         d.rvalid = 1'b0;
      if (s_axi_arvalid_i && q.arready)
      begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         case (s_axi_araddr_i)
            ADDR_UPPER_RB: d.rdata = q.rb;
            ADDR_CMD_STS: d.rdata = {30'h0, q.init_done, q.pending};
            ADDR_AGING_CFG: d.rdata = cfg_word(q);
            ADDR_GLOBAL_CTRL: d.rdata = {31'h0, q.glob_prio};
            ADDR_IRQ_STS: d.rdata = {29'h0, q.irq_sts};
            ADDR_IRQ_MASK: d.rdata = {29'h0, q.irq_mask};
            default:
            begin
               d.rdata = 32'h0;
               d.rresp = RESP_SLVERR;
            end
         endcase
      end
      d.arready = !d.rvalid;
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         q <= '0;
         q.st <= ST_INIT;
         q.drop <= 1'b1;
         q.age_time <= AGE_TIME_RST;
         q.age_en <= AGE_EN_RST;
         q.age_test <= AGE_TEST_RST;
         q.bcast <= BCAST_RST;
      end
      else if (ce_i)
         q <= d;
   end

   ////////////////////////////////////////////////////////////////////////////
   assign s_axi_awready_o = q.awready;
   assign s_axi_wready_o = q.wready;
   assign s_axi_bvalid_o = q.bvalid;
   assign s_axi_bresp_o = q.bresp;
   assign s_axi_arready_o = q.arready;
   assign s_axi_rvalid_o = q.rvalid;
   assign s_axi_rdata_i_unused_o = q.rdata;
   assign s_axi_rresp_o = q.rresp;
   assign init_done_o = q.init_done;
   assign drop_rx_o = q.drop;
   assign tbl_clr_we_o = q.tbl_we;
   assign tbl_clr_addr_o = q.tbl_addr;
   assign fwd_prio_valid_o = q.prio_valid;
   assign fwd_prio_o = q.prio;
   assign fwd_port_mask_o = q.pmask;
   assign allow_bcast_o = q.bcast;
   assign age_sweep_o = q.sweep;
   assign age_evict_o = q.evict;
   assign irq_o = q.irq;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   a_prio_gate: assert property (ce_i && match_valid_i |=>
      fwd_prio_valid_o == $past(match_prio_en_i && q.glob_prio))
      else $error("priority applied without both enables");
   a_port_single: assert property (ce_i && match_valid_i && !match_ports_i[2]
      |=> $onehot0(fwd_port_mask_o))
      else $error("single port code gave several ports");
   a_port_resvd: assert property (ce_i && match_valid_i && match_ports_i == 3'h3
      |=> fwd_port_mask_o == 3'h0)
      else $error("reserved port code selected a port");
   a_mac_tail: assert property (ce_i && entry_load_i |=>
      q.rb[15:0] == $past(entry_upper_i[15:0]))
      else $error("mac tail not loaded");
   a_init_time: assert property ($rose(init_done_o) |-> $past(q.init_cnt) == INIT_LAST)
      else $error("init done at wrong count");
   a_pend_clear: assert property (ce_i && cmd_done_i && !cmd_start_i |=> !q.pending)
      else $error("pending did not self-clear");
   a_valid_clear: assert property (ce_i && cmd_get_i && !entry_load_i
      |=> !q.rb[RB_VALID])
      else $error("valid not cleared by get command");
   a_age_gate: assert property (ce_i && !q.age_en |=> !age_sweep_o && !age_evict_o)
      else $error("aging active while disabled");
   a_static_keep: assert property (age_evict_o |-> !$past(age_cand_static_i))
      else $error("static entry evicted");

endmodule : atsc_top

// *** verif/tb.sv ***
module tb
   import atsc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_i, reset_n_i, ce_i;
   logic [15:0] awaddr, araddr;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata, rdata, entry_upper_i, cfg_m, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   logic cmd_start_i, cmd_done_i, cmd_get_i, entry_load_i, entry_found_i, entry_end_i;
   logic match_valid_i, match_prio_en_i, age_cand_valid_i, age_cand_static_i, age_cand_idle_i;
   logic [2:0] match_prio_i, match_ports_i, fwd_prio_o, fwd_port_mask_o, irq_m;
   logic init_done_o, drop_rx_o, tbl_clr_we_o, fwd_prio_valid_o, allow_bcast_o;
   logic age_sweep_o, age_evict_o, irq_o;
   logic [8:0] tbl_clr_addr_o;
   int err_total, checked, cyc, max_addr, sw, ncyc;
   logic [31:0] got;
   localparam int P_START = 0;
   localparam int P_DONE = 1;
   localparam int P_GET = 2;
   localparam int P_LOAD = 3;
   logic [2:0] map [8] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};

   atsc_top #(.SEC_CYC(20), .MS_CYC(4)) uut (.clk_i, .reset_n_i, .ce_i,
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_i_unused_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .cmd_start_i, .cmd_done_i,
      .cmd_get_i, .entry_load_i, .entry_found_i, .entry_end_i, .entry_upper_i,
      .match_valid_i, .match_prio_en_i, .match_prio_i, .match_ports_i, .age_cand_valid_i,
      .age_cand_static_i, .age_cand_idle_i, .init_done_o, .drop_rx_o, .tbl_clr_we_o,
      .tbl_clr_addr_o, .fwd_prio_valid_o, .fwd_prio_o, .fwd_port_mask_o, .allow_bcast_o,
      .age_sweep_o, .age_evict_o, .irq_o);

   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic give_up(input string nm);
      err_total++;
      $display("MISMATCH %s expected answer seen timeout", nm);
      close_out();
   endtask : give_up

   // Ready and valid are sampled at the falling edge; registered, so they hold to the next rise
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] rsp);
      int n;
      logic aw_t, w_t, b_t;
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      b_t = 1'h0;
      n = 0;
      while (!b_t)
      begin
         @(negedge clk_i);
         aw_t = awvalid & awready;
         w_t = wvalid & wready;
         b_t = bvalid;
         rsp = bresp;
         @(posedge clk_i);
         if (aw_t)
            awvalid <= 1'h0;
         if (w_t)
            wvalid <= 1'h0;
         n++;
         if (n > 100)
            give_up("write");
      end
      bready <= 1'h0;
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] rsp);
      int n;
      logic ar_t, r_t;
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      r_t = 1'h0;
      n = 0;
      while (!r_t)
      begin
         @(negedge clk_i);
         ar_t = arvalid & arready;
         r_t = rvalid;
         d = rdata;
         rsp = rresp;
         @(posedge clk_i);
         if (ar_t)
            arvalid <= 1'h0;
         n++;
         if (n > 100)
            give_up("read");
      end
      rready <= 1'h0;
   endtask : rd

   // One-cycle strobe on one engine input, then two idle cycles
   task automatic pulse(input int w);
      logic [3:0] m;
      m = 4'h1 << w;
      @(posedge clk_i);
      {entry_load_i, cmd_get_i, cmd_done_i, cmd_start_i} <= m;
      @(posedge clk_i);
      {entry_load_i, cmd_get_i, cmd_done_i, cmd_start_i} <= 4'h0;
      repeat (2) @(posedge clk_i);
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_i = 1'h0;
      forever #2.5 clk_i = ~clk_i;
   end

   always @(posedge clk_i)
      if (tbl_clr_we_o === 1'h1 && tbl_clr_addr_o > max_addr)
         max_addr <= tbl_clr_addr_o;

   // Edges since reset release, independent of bus latency
   always @(posedge clk_i)
      if (reset_n_i === 1'h1)
         ncyc <= ncyc + 1;

   initial
   begin
      repeat (100000) @(posedge clk_i);
      give_up("run length");
   end

   initial
   begin
      void'($urandom(32'hdb785bce));
      {reset_n_i, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      {cmd_start_i, cmd_done_i, cmd_get_i, entry_load_i, entry_found_i, entry_end_i} = '0;
      {match_valid_i, match_prio_en_i, match_prio_i, match_ports_i, entry_upper_i} = '0;
      {age_cand_valid_i, age_cand_static_i, age_cand_idle_i, wstrb} = '0;
      ce_i = 1'h1;
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'h1;
      rd(ADDR_CMD_STS, v, rs);
      chk("status in init", v, 32'h0);
      chk("drop in init", 32'(drop_rx_o), 32'h1);
      rd(ADDR_AGING_CFG, v, rs);
      chk("cfg reset", v, 32'h01290002);
      rd(ADDR_UPPER_RB, v, rs);
      chk("readback reset", v, 32'h0);
      while (init_done_o !== 1'h1 && ncyc < 5000)
         @(negedge clk_i);
      if (init_done_o !== 1'h1)
         give_up("init wait");
      chk("init length", ncyc, INIT_CYC);
      chk("table cleared", max_addr, 511);
      @(negedge clk_i);
      chk("drop after init", 32'(drop_rx_o), 32'h0);
      // Software sees the done flag before any table register write
      rd(ADDR_CMD_STS, v, rs);
      chk("init flag", v, 32'h2);
      $display("test init done");
      // Random config, partial strobe, read-only and unmapped writes
      v = $urandom();
      wr(ADDR_AGING_CFG, v, 4'hf, rs);
      cfg_m = v & 32'h0fff0007;
      v = $urandom();
      wr(ADDR_AGING_CFG, v, 4'h4, rs);
      cfg_m = (cfg_m & 32'hff00ffff) | (v & 32'h00ff0000);
      rd(ADDR_AGING_CFG, v, rs);
      chk("cfg merge", v, cfg_m);
      chk("bcast out", 32'(allow_bcast_o), 32'(cfg_m[2]));
      wr(ADDR_CMD_STS, 32'hffffffff, 4'hf, rs);
      chk("ro resp", 32'(rs), 32'(RESP_OKAY));
      rd(ADDR_CMD_STS, v, rs);
      chk("ro status", v, 32'h2);
      wr(16'h0100, 32'h1, 4'hf, rs);
      chk("unmapped wr", 32'(rs), 32'(RESP_SLVERR));
      rd(16'h0100, v, rs);
      chk("unmapped rd data", v, 32'h0);
      chk("unmapped rd resp", 32'(rs), 32'(RESP_SLVERR));
      $display("test registers done");
      // Pending flag
      pulse(P_START);
      rd(ADDR_CMD_STS, v, rs);
      chk("pending set", v, 32'h3);
      pulse(P_DONE);
      rd(ADDR_CMD_STS, v, rs);
      chk("pending clear", v, 32'h2);
      irq_m = 3'h3;
      // Upper readback loads and get command
      for (int i = 0; i < 4; i++)
      begin
         entry_upper_i <= $urandom();
         entry_found_i <= (i == 0) ? 1'h1 : 1'($urandom());
         entry_end_i <= 1'($urandom());
         pulse(P_LOAD);
         if (entry_found_i)
            irq_m[2] = 1'h1;
         v = {4'h0, entry_end_i, entry_found_i, entry_upper_i[25:0]};
         rd(ADDR_UPPER_RB, got, rs);
         chk("upper rb", got, v);
         pulse(P_GET);
         v[26] = 1'h0;
         rd(ADDR_UPPER_RB, got, rs);
         chk("valid after get", got, v);
      end
      $display("test readback done");
      // Destination match decode over all codes
      for (int g = 0; g < 2; g++)
      begin
         wr(ADDR_GLOBAL_CTRL, 32'(g), 4'hf, rs);
         for (int c = 0; c < 16; c++)
         begin
            @(posedge clk_i);
            match_valid_i <= 1'h1;
            match_ports_i <= 3'(c);
            match_prio_en_i <= c[3];
            match_prio_i <= 3'($urandom());
            repeat (2) @(posedge clk_i);
            @(negedge clk_i);
            chk("port mask", 32'(fwd_port_mask_o), 32'(map[c[2:0]]));
            chk("prio valid", 32'(fwd_prio_valid_o), 32'(c[3] & g[0]));
            if (c[3] & g[0])
               chk("prio", 32'(fwd_prio_o), 32'(match_prio_i));
         end
      end
      @(posedge clk_i);
      match_valid_i <= 1'h0;
      $display("test decode done");
      // Aging period, unit and enable; eviction
      age_cand_valid_i <= 1'h1;
      age_cand_idle_i <= 1'h1;
      for (int k = 0; k < 3; k++)
      begin
         wr(ADDR_AGING_CFG, {16'h0001, 14'h0, k < 2, k == 0}, 4'hf, rs);
         sw = 0;
         repeat (160)
         begin
            @(negedge clk_i);
            if (age_sweep_o === 1'h1)
               sw++;
         end
         cyc = (k == 0) ? 20 : (k == 1) ? 4 : 0;
         chk("sweeps", 32'(sw >= cyc - 1 && sw <= cyc + 1), 32'h1);
         for (int s = 0; s < 2; s++)
         begin
            @(posedge clk_i);
            age_cand_static_i <= 1'(s);
            repeat (2) @(posedge clk_i);
            @(negedge clk_i);
            chk("evict", 32'(age_evict_o), 32'(s == 0 && k < 2));
         end
      end
      @(posedge clk_i);
      age_cand_valid_i <= 1'h0;
      $display("test aging done");
      // Interrupt status, mask and clear
      rd(ADDR_IRQ_STS, v, rs);
      chk("irq status", v, {29'h0, irq_m});
      chk("irq masked", 32'(irq_o), 32'h0);
      wr(ADDR_IRQ_MASK, 32'h2, 4'hf, rs);
      repeat (3) @(negedge clk_i);
      chk("irq raised", 32'(irq_o), 32'h1);
      wr(ADDR_IRQ_STS, 32'h2, 4'hf, rs);
      repeat (3) @(negedge clk_i);
      chk("irq cleared", 32'(irq_o), 32'h0);
      rd(ADDR_IRQ_STS, v, rs);
      chk("irq w1c", v, {29'h0, irq_m & 3'h5});
      $display("test interrupt done");
      close_out();
   end

endmodule : tb
